// *** rtl/ipv_select.sv ***
// Module: priority promotion and vector selection
`default_nettype none
// Operation
// (RQ1) Priority select field promotes one maskable source above all others.
// (RQ2) Field writes accepted only while the I mask is set.
// (RQ3) Codes 00110/00111 promote pin request/periodic; reserved codes act as pin.
// (RQ4) Codes 01000-01111 promote captures 1-3, compares 1-4, shared channel.
// (RQ5) Codes 10000-11001 promote overflow, accumulator, serial, pulse, keypad.
// (RQ6) Reset sources vector FFFE, FFFC, FFFA, unmasked by condition bits.
// (RQ7) Nonmaskable pin FFF4 gated by X; software FFF6, illegal FFF8.
// (RQ8) Timer sources vector FFEE down to FFDE with I and local enable.
// (RQ9) First serial unit shares FFCE for all its enabled events.
// (RQ10) Second serial unit shares FFD6 for all its enabled events.
// (RQ11) Accumulator edge FFDA, accumulator overflow FFDC, locally enabled.
// (RQ12) Keypad FFCC gated by four-bit mask; FFC0-FFCB reserved.
// (RQ13) Serial periph FFD8, pulse FFD0, periodic FFF0, pin FFF2.
// (RQ14) Reset loads priority select with 00110.
// (RQ15) Promoted source stays subject to I mask and local enables.
// (RQ16) Promotion keeps vectors and default order of other sources.
module ipv_select
    import ipv_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ccr_i_mask,
    input  wire logic        ccr_x_mask,
    input  wire logic        por_reset,
    input  wire logic        clock_monitor_fail,
    input  wire logic        clock_monitor_enable,
    input  wire logic        watchdog_fail,
    input  wire logic        window_watchdog_fail,
    input  wire logic        illegal_opcode,
    input  wire logic        software_int,
    input  wire logic        nonmaskable_request_pin,
    input  wire logic        slow_periodic_interrupt,
    input  wire logic        irq_pin_req,
    input  wire logic        periodic_flag,
    input  wire logic        periodic_int_enable,
    input  wire logic [2:0]  capture_flag,
    input  wire logic [2:0]  capture_int_enable,
    input  wire logic [3:0]  compare_flag,
    input  wire logic [3:0]  compare_int_enable,
    input  wire logic        shared_ch_flag,
    input  wire logic        shared_ch_int_enable,
    input  wire logic        timer_overflow_flag,
    input  wire logic        timer_overflow_int_enable,
    input  wire logic        pulse_width_flag,
    input  wire logic        pulse_width_int_enable,
    input  wire logic        accum_overflow_flag,
    input  wire logic        accum_overflow_int_enable,
    input  wire logic        accum_edge_flag,
    input  wire logic        accum_edge_int_enable,
    input  wire logic [4:0]  first_async_serial_flag,
    input  wire logic [3:0]  first_async_serial_enable,
    input  wire logic [3:0]  keypad_flag,
    input  wire logic [3:0]  keypad_mask,
    input  wire logic        serial_periph_flag,
    input  wire logic        serial_periph_int_enable,
    input  wire logic [4:0]  second_async_serial_flag,
    input  wire logic [3:0]  second_async_serial_enable,
    output logic             vector_valid,
    output logic [15:0]      vector_addr,
    output logic             irq_out
);
    ipv_state_s  st_ff;
    ipv_state_s  nxt_st;
    logic [IPV_NSRC-1:0] req;
    logic [4:0]  slot;
    logic        pvalid;
    logic [4:0]  pslot;
    logic        any_m;
    logic [4:0]  sel_m;
    logic [15:0] vec_c;
    logic        vld_c;
    logic [6:0]  ev;
    logic [4:0]  a1;
    logic [4:0]  a2;
    logic        quiet_nm;

    // Serial units: rx full and overrun share the receive enable
    always_comb begin
        a1 = {first_async_serial_flag[4] & first_async_serial_enable[3],
              first_async_serial_flag[3] & first_async_serial_enable[2],
              first_async_serial_flag[2] & first_async_serial_enable[1],
              first_async_serial_flag[1] & first_async_serial_enable[0],
              first_async_serial_flag[0] & first_async_serial_enable[0]};
        a2 = {second_async_serial_flag[4] & second_async_serial_enable[3],
              second_async_serial_flag[3] & second_async_serial_enable[2],
              second_async_serial_flag[2] & second_async_serial_enable[1],
              second_async_serial_flag[1] & second_async_serial_enable[0],
              second_async_serial_flag[0] & second_async_serial_enable[0]};
    end

    // Requests in default order, slots 6..23, locally enabled except the pin in slot 6
    always_comb begin
        req = '0;
        req[6] = irq_pin_req; // RQ13
        req[7] = periodic_flag & periodic_int_enable; // RQ13
        req[8] = capture_flag[0] & capture_int_enable[0]; // RQ8
        req[9] = capture_flag[1] & capture_int_enable[1]; // RQ8
        req[10] = capture_flag[2] & capture_int_enable[2]; // RQ8
        req[11] = compare_flag[0] & compare_int_enable[0]; // RQ8
        req[12] = compare_flag[1] & compare_int_enable[1]; // RQ8
        req[13] = compare_flag[2] & compare_int_enable[2]; // RQ8
        req[14] = compare_flag[3] & compare_int_enable[3]; // RQ8
        req[15] = shared_ch_flag & shared_ch_int_enable; // RQ8
        req[16] = timer_overflow_flag & timer_overflow_int_enable; // RQ8
        req[17] = pulse_width_flag & pulse_width_int_enable; // RQ13
        req[18] = accum_overflow_flag & accum_overflow_int_enable; // RQ11
        req[19] = accum_edge_flag & accum_edge_int_enable; // RQ11
        req[20] = |a1; // RQ9
        req[21] = |(keypad_flag & keypad_mask); // RQ12
        req[22] = serial_periph_flag & serial_periph_int_enable; // RQ13
        req[23] = |a2; // RQ10
    end

    // Map priority select code to slot
    always_comb begin
        case (st_ff.psel)
            5'h07: slot = 5'd7; // RQ3
            5'h08, 5'h09, 5'h0A, 5'h0B,
            5'h0C, 5'h0D, 5'h0E, 5'h0F: slot = st_ff.psel; // RQ4
            5'h10: slot = 5'd16; // RQ5
            5'h11: slot = 5'd18; // RQ5
            5'h12: slot = 5'd19; // RQ5
            5'h13: slot = 5'd22; // RQ5
            5'h14: slot = 5'd23; // RQ5
            5'h17: slot = 5'd17; // RQ5
            5'h18: slot = 5'd20; // RQ5
            5'h19: slot = 5'd21; // RQ5
            default: slot = 5'd6; // RQ3
        endcase
        pslot = slot;
    end

    // Promoted first, then fixed order; masking unchanged
    always_comb begin
        pvalid = req[pslot] & ~ccr_i_mask; // RQ1 RQ15
        any_m = 1'b0;
        sel_m = 5'd6;
        for (int i = IPV_NSRC - 1; i >= 6; i--) begin
            if (req[i] && !ccr_i_mask) begin
                any_m = 1'b1; // RQ16
                sel_m = 5'(i);
            end
        end
        if (pvalid) begin
            sel_m = pslot; // RQ1
        end
    end

    // Fixed nonmaskable order, then maskable
    always_comb begin
        vld_c = 1'b1;
        if (por_reset) begin
            vec_c = VEC_RESET; // RQ6
        end else if (clock_monitor_fail && clock_monitor_enable) begin
            vec_c = VEC_CLKMON; // RQ6
        end else if (watchdog_fail || window_watchdog_fail) begin
            vec_c = VEC_WDOG; // RQ6
        end else if (illegal_opcode) begin
            vec_c = VEC_ILLOP; // RQ7
        end else if (software_int) begin
            vec_c = VEC_SWI; // RQ7
        end else if ((nonmaskable_request_pin || slow_periodic_interrupt)
                     && !ccr_x_mask) begin
            vec_c = VEC_NMI; // RQ7
        end else if (any_m) begin
            vec_c = VEC_TABLE[sel_m*16 +: 16]; // RQ16
        end else begin
            vec_c = VEC_NONE;
            vld_c = 1'b0;
        end
    end

    // Events for sticky status: priority write refused, nonmaskable pin vector, maskable request pending unpromoted or promoted
    always_comb begin
        ev = '0;
        ev[0] = avs_write && avs_address == OFF_PSEL && !ccr_i_mask;
        ev[1] = vld_c && vec_c == VEC_NMI;
        ev[2] = any_m && !pvalid;
        ev[3] = pvalid;
    end

    // Register file and state update
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.stat = st_ff.stat | ev;
        if (avs_write) begin
            case (avs_address)
                OFF_PSEL: begin
                    if (ccr_i_mask) begin
                        nxt_st.psel = avs_writedata[4:0]; // RQ2
                    end
                end
                OFF_MASK: nxt_st.mask = avs_writedata[6:0];
                default: ;
            endcase
        end
        if (avs_read && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            case (avs_address)
                OFF_PSEL: nxt_st.rdata = {27'h0, st_ff.psel};
                OFF_STAT: begin
                    nxt_st.rdata = {25'h0, st_ff.stat};
                    nxt_st.stat = ev;
                end
                OFF_MASK: nxt_st.rdata = {25'h0, st_ff.mask};
                OFF_VECT: nxt_st.rdata = {15'h0, vld_c, vec_c};
                default: nxt_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{psel: PSEL_RST, stat: 7'h00, mask: 7'h00,
                       rdata: 32'h0, rvalid: 1'b0}; // RQ14
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        avs_waitrequest = avs_read && !st_ff.rvalid;
        avs_readdata = st_ff.rdata;
        vector_valid = vld_c;
        vector_addr = vec_c;
        irq_out = |(st_ff.stat & st_ff.mask);
    end

    // No reset or nonmaskable source pending
    always_comb begin
        quiet_nm = !(por_reset || clock_monitor_fail || watchdog_fail
                     || window_watchdog_fail || illegal_opcode
                     || software_int || nonmaskable_request_pin
                     || slow_periodic_interrupt);
    end

    a_psel_guard: assert property (@(posedge mclk) // RQ2
        disable iff (!rst_n)
        (avs_write && avs_address == OFF_PSEL && !ccr_i_mask)
        |=> $stable(st_ff.psel))
        else $error("priority field changed with I clear");
    a_refuse_flag: assert property (@(posedge mclk) // RQ2
        disable iff (!rst_n)
        (avs_write && avs_address == OFF_PSEL && !ccr_i_mask)
        |=> st_ff.stat[0])
        else $error("refused priority write not flagged");
    a_reset_top: assert property (@(posedge mclk) // RQ6
        disable iff (!rst_n)
        por_reset |-> vector_addr == 16'hFFFE)
        else $error("reset vector wrong");
    a_i_mask_gate: assert property (@(posedge mclk) // RQ15
        disable iff (!rst_n)
        (ccr_i_mask && vector_valid) |-> vector_addr >= 16'hFFF4)
        else $error("maskable vector while I set");
    a_x_gate: assert property (@(posedge mclk) // RQ7
        disable iff (!rst_n)
        (ccr_x_mask && vector_addr == 16'hFFF4) |-> 1'b0)
        else $error("nonmaskable pin vector while X set");
    a_promote_pin: assert property (@(posedge mclk) // RQ1
        disable iff (!rst_n)
        (st_ff.psel == 5'h06 && irq_pin_req && !ccr_i_mask && quiet_nm)
        |-> vector_addr == 16'hFFF2)
        else $error("pin request not first");
    a_promote_wins: assert property (@(posedge mclk) // RQ4
        disable iff (!rst_n)
        (st_ff.psel == 5'h0B && compare_flag[0] && compare_int_enable[0]
         && !ccr_i_mask && quiet_nm) |-> vector_addr == 16'hFFE8)
        else $error("promoted compare not first");
    a_default_order: assert property (@(posedge mclk) // RQ16
        disable iff (!rst_n)
        (st_ff.psel == 5'h06 && !irq_pin_req && periodic_flag
         && periodic_int_enable && !ccr_i_mask && quiet_nm)
        |-> vector_addr == 16'hFFF0)
        else $error("default order broken");
    a_swi_vec: assert property (@(posedge mclk) // RQ7
        disable iff (!rst_n)
        (software_int && !por_reset && !illegal_opcode && !watchdog_fail
         && !window_watchdog_fail && !clock_monitor_fail)
        |-> vector_addr == 16'hFFF6)
        else $error("software vector wrong");
    a_reserved_map: assert property (@(posedge mclk) // RQ3
        disable iff (!rst_n)
        (st_ff.psel[4:2] == 3'b111) |-> pslot == 5'd6)
        else $error("reserved code not pin");
    a_vec_range: assert property (@(posedge mclk) // RQ12
        disable iff (!rst_n)
        vector_valid |-> (vector_addr >= 16'hFFCC && !vector_addr[0]))
        else $error("vector in reserved range");
    a_stat_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (avs_read && avs_address == OFF_STAT && avs_waitrequest
         && ev == '0) |=> st_ff.stat == '0)
        else $error("status not cleared by read");
    a_read_answer: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("read not answered in one cycle");
endmodule
`default_nettype wire

// *** rtl/ipv_pkg.sv ***
// Package: constants for interrupt priority and vector selection
`default_nettype none
package ipv_pkg;
    localparam int          IPV_NSRC = 24;
    localparam logic [4:0]  PSEL_RST = 5'h06;
    localparam logic [1:0]  OFF_PSEL = 2'h0;
    localparam logic [1:0]  OFF_STAT = 2'h1;
    localparam logic [1:0]  OFF_MASK = 2'h2;
    localparam logic [1:0]  OFF_VECT = 2'h3;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
    localparam logic [15:0] VEC_WDOG = 16'hFFFA;
    localparam logic [15:0] VEC_ILLOP = 16'hFFF8;
    localparam logic [15:0] VEC_SWI = 16'hFFF6;
    localparam logic [15:0] VEC_NMI = 16'hFFF4;
    localparam logic [15:0] VEC_NONE = 16'h0000;
    // Maskable slots in default order, slot 6 = external request pin
    localparam logic [IPV_NSRC*16-1:0] VEC_TABLE = {
        16'hFFD6, 16'hFFD8, 16'hFFCC, 16'hFFCE,
        16'hFFDA, 16'hFFDC, 16'hFFD0, 16'hFFDE,
        16'hFFE0, 16'hFFE2, 16'hFFE4, 16'hFFE6,
        16'hFFE8, 16'hFFEA, 16'hFFEC, 16'hFFEE,
        16'hFFF0, 16'hFFF2, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    typedef struct packed {
        logic [4:0]  psel;
        logic [6:0]  stat;
        logic [6:0]  mask;
        logic [31:0] rdata;
        logic        rvalid;
    } ipv_state_s;
endpackage
`default_nettype wire

// *** test/ipv_cpu_model.sv ***
// CPU core model: holds mask bits, fetches vectors
`default_nettype none
module ipv_cpu_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        want_i,
    input  wire logic        want_x,
    input  wire logic        vector_valid,
    input  wire logic [15:0] vector_addr,
    output logic             ccr_i_mask,
    output logic             ccr_x_mask,
    output logic [15:0]      fetched
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ccr_i_mask <= 1'b1;
            ccr_x_mask <= 1'b1;
            fetched    <= 16'h0000;
        end else begin
            ccr_i_mask <= want_i;
            ccr_x_mask <= want_x & ccr_x_mask;
            if (vector_valid) begin
                fetched <= vector_addr;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/interrupt_priority_vector_select_tb.sv ***
// Testbench for priority promotion and vector selection
`default_nettype none
module interrupt_priority_vector_select_tb import ipv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst_n, want_i, want_x, avs_read, avs_write;
    logic        avs_waitrequest, ccr_i_mask, ccr_x_mask;
    logic        vector_valid, irq_out;
    logic [1:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] vector_addr, fetched;
    logic [16:0] e;
    logic [63:0] s;
    logic [4:0]  psel_m;
    int          bad_count = 0;
    int          tests_run = 0;
    localparam logic [15:0] VT [18] = '{16'hFFF2, 16'hFFF0, 16'hFFEE,
        16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2,
        16'hFFE0, 16'hFFDE, 16'hFFD0, 16'hFFDC, 16'hFFDA, 16'hFFCE,
        16'hFFCC, 16'hFFD8, 16'hFFD6};
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ipv_cpu_model cpu_u (.mclk(mclk), .rst_n(rst_n), .want_i(want_i),
        .want_x(want_x), .vector_valid(vector_valid),
        .vector_addr(vector_addr), .ccr_i_mask(ccr_i_mask),
        .ccr_x_mask(ccr_x_mask), .fetched(fetched));
    ipv_select dut_u (.mclk(mclk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ccr_i_mask(ccr_i_mask), .ccr_x_mask(ccr_x_mask),
        .por_reset(s[63]), .clock_monitor_fail(s[62]),
        .clock_monitor_enable(s[61]), .watchdog_fail(s[60]),
        .window_watchdog_fail(s[59]), .illegal_opcode(s[58]),
        .software_int(s[57]), .nonmaskable_request_pin(s[56]),
        .slow_periodic_interrupt(s[55]), .irq_pin_req(s[54]),
        .periodic_flag(s[53]), .periodic_int_enable(s[52]),
        .capture_flag(s[51:49]), .capture_int_enable(s[48:46]),
        .compare_flag(s[45:42]), .compare_int_enable(s[41:38]),
        .shared_ch_flag(s[37]), .shared_ch_int_enable(s[36]),
        .timer_overflow_flag(s[35]), .timer_overflow_int_enable(s[34]),
        .pulse_width_flag(s[33]), .pulse_width_int_enable(s[32]),
        .accum_overflow_flag(s[31]), .accum_overflow_int_enable(s[30]),
        .accum_edge_flag(s[29]), .accum_edge_int_enable(s[28]),
        .first_async_serial_flag(s[27:23]),
        .first_async_serial_enable(s[22:19]),
        .keypad_flag(s[18:15]), .keypad_mask(s[14:11]),
        .serial_periph_flag(s[10]), .serial_periph_int_enable(s[9]),
        .second_async_serial_flag(s[8:4]),
        .second_async_serial_enable(s[3:0]),
        .vector_valid(vector_valid), .vector_addr(vector_addr),
        .irq_out(irq_out));
    // Expected {valid, vector} from sources, masks and select code
    function automatic logic [16:0] exp_vec(logic [63:0] v, logic i,
        logic x, logic [4:0] p);
        logic [17:0] pd;
        int          h;
        pd = {|(v[8:4] & {v[3:1], v[0], v[0]}), v[10] & v[9],
            |(v[18:15] & v[14:11]), |(v[27:23] & {v[22:20], v[19], v[19]}),
            v[29] & v[28], v[31] & v[30], v[33] & v[32], v[35] & v[34],
            v[37] & v[36], v[45:42] & v[41:38], v[51:49] & v[48:46],
            v[53] & v[52], v[54]};
        case (p) inside
            [5'h08:5'h0F]: h = int'(p) - 6;
            5'h07: h = 1;
            5'h10: h = 10;
            5'h11: h = 12;
            5'h12: h = 13;
            5'h13: h = 16;
            5'h14: h = 17;
            5'h17: h = 11;
            5'h18: h = 14;
            5'h19: h = 15;
            default: h = 0;
        endcase
        if (v[63]) return {1'b1, 16'hFFFE};
        if (v[62] & v[61]) return {1'b1, 16'hFFFC};
        if (v[60] | v[59]) return {1'b1, 16'hFFFA};
        if (v[58]) return {1'b1, 16'hFFF8};
        if (v[57]) return {1'b1, 16'hFFF6};
        if ((v[56] | v[55]) & !x) return {1'b1, 16'hFFF4};
        if (i) return 17'h00000;
        if (pd[h]) return {1'b1, VT[h]};
        for (int k = 0; k < 18; k++) if (pd[k]) return {1'b1, VT[k]};
        return 17'h00000;
    endfunction
    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk_reg(logic [31:0] got, logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            bad_count++;
            $display("CHECK FAILED %0t reg %h want %h", $time, got, want);
        end
    endtask
    task automatic chk_vec(logic [16:0] w);
        tests_run++;
        if (w[16] ? {vector_valid, vector_addr} !== w : vector_valid !== 0)
        begin
            bad_count++;
            $display("CHECK FAILED %0t vector want %h", $time, w);
        end
    endtask
    task automatic bus(logic rd, logic [1:0] a, logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic setp(logic [4:0] c);
        @(posedge mclk);
        want_i <= 1'b1;
        @(posedge mclk);
        bus(0, OFF_PSEL, {27'h0, c});
        psel_m = c;
        bus(1, OFF_PSEL, 32'h0);
        chk_reg(q, {27'h0, psel_m});
    endtask
    initial begin
        #500000;
        bad_count++;
        print_verdict();
    end
    initial begin
        {rst_n, want_i, want_x, s, avs_read, avs_write} = {3'b011, 66'h0};
        avs_address = 2'h0;
        avs_writedata = 32'h0;
        psel_m = PSEL_RST;
        void'($urandom(32'h2A70));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1, OFF_PSEL, 32'h0);
        chk_reg(q, {27'h0, PSEL_RST});
        @(posedge mclk);
        want_i <= 1'b0;
        bus(0, OFF_PSEL, 32'h0000_0008);
        bus(1, OFF_PSEL, 32'h0);
        chk_reg(q, {27'h0, PSEL_RST});
        chk_reg({31'h0, irq_out}, 32'h0);
        bus(0, OFF_MASK, 32'h0000_0001);
        @(negedge mclk);
        chk_reg({31'h0, irq_out}, 32'h1);
        bus(1, OFF_STAT, 32'h0);
        chk_reg(q, 32'h1);
        @(negedge mclk);
        chk_reg({31'h0, irq_out}, 32'h0);
        @(posedge mclk);
        s <= 64'h0030_0000_0000_0000;
        bus(1, OFF_STAT, 32'h0);
        chk_reg(q, 32'h4);
        @(posedge mclk);
        s <= 64'h0040_0000_0000_0000;
        bus(1, OFF_STAT, 32'h0);
        chk_reg(q, 32'hC);
        for (int c = 0; c < 32; c++) begin
            setp(5'(c));
            want_i <= 1'b0;
            s <= (c < 16) ? 64'h007F_FFFF_FFFF_FFFF : {$urandom, $urandom};
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            e = exp_vec(s, ccr_i_mask, ccr_x_mask, psel_m);
            chk_vec(e);
            if (e[16]) chk_reg({16'h0, fetched}, {16'h0, e[15:0]});
            bus(1, OFF_VECT, 32'h0);
            chk_reg(q, {15'h0, e});
        end
        for (int n = 0; n < 400; n++) begin
            if (n % 50 == 0) setp(5'($urandom));
            @(posedge mclk);
            s <= {$urandom, $urandom} & {$urandom, $urandom}
                & ((n % 4 == 0) ? '1 : 64'h007F_FFFF_FFFF_FFFF);
            want_i <= ($urandom % 4 == 0);
            want_x <= (n < 200);
            @(negedge mclk);
            chk_vec(exp_vec(s, ccr_i_mask, ccr_x_mask, psel_m));
        end
        print_verdict();
    end
endmodule
`default_nettype wire
